// >>> inc/cpsc_params.svh
// Register offsets, fields, reset values and timing counts of the clock block
`ifndef CPSC_PARAMS_SVH
`define CPSC_PARAMS_SVH
`define CPSC_OFF_TRIM 12'h000
`define CPSC_OFF_DIV 12'h004
`define CPSC_OFF_SLEEP 12'h008
`define CPSC_OFF_STATUS 12'h00C
`define CPSC_DIV_UNLOCK_BIT 7
`define CPSC_UNLOCK_WRITE 8'h80
`define CPSC_DIV_RESET_PLAIN 4'h0
`define CPSC_DIV_RESET_EIGHT 4'h3
`define CPSC_DIV_MAX 4'h8
`define CPSC_UNLOCK_CYCLES 3'h4
`define CPSC_WAKE_HOLD_CYCLES 4'h4
`define CPSC_STANDBY_WAKE_CYCLES 4'h6
`define CPSC_POWERDOWN_WAKE_CYCLES 4'h6
`define CPSC_SLEEP_ALLOW_BIT 2
`endif

// >>> inc/cpsc_pkg.sv
// Types shared by the clock prescale and sleep controller
package cpsc_pkg;
  typedef enum logic [1:0] {
    CPSC_IDLE, CPSC_ADC_QUIET, CPSC_POWER_DOWN, CPSC_STANDBY
  } cpsc_kind_t;
  typedef enum {CPSC_RUN, CPSC_SLEEP, CPSC_WAKE} cpsc_state_t;
endpackage

// >>> logic/cpsc_clock_ctrl.sv
// Clock prescaler, oscillator trim and sleep controller with APB registers
// What this block does
// - Reset loads factory trim; software may overwrite
// - Top trim bit selects oscillator range
// - Low seven bits tune within range
// - Unlock set only by exact 0x80 write
// - Unlock clears after four cycles or divide write
// - Rewriting unlock neither restarts nor clears it
// - Divide changes only inside unlock window
// - Prescaler bits six to four read zero
// - Reset divide is zero or three by fuse
// - Any divide value accepted regardless of fuse
// - Codes zero to eight divide by powers
// - Divided clock enables all synchronous domains
// - Sleep request acts only when allowed
// - Wake holds core four cycles after start-up, except standby (six in all)
// - State kept in sleep; reset wakes to vector
// - Idle stops core and flash clocks only
// - ADC quiet stops I/O, core, flash clocks
// - Power-down stops oscillator and all clocks
// - Standby keeps oscillator, wakes in six cycles
// - Divider switch makes no glitch or short period
// - New rate active within old plus new periods
//
// Chosen here: the APB interface to the registers and the address map.
`include "cpsc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module cpsc_clock_ctrl
  import cpsc_pkg::*;
#(
  parameter logic [7:0] FACTORY_TRIM = 8'h5A // Arbitrary default
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic start_div_eight_fuse,
  input wire logic sleep_req,
  input wire logic ext_crystal_sel,
  input wire logic wake_irq,
  input wire logic wake_ext_level,
  input wire logic wake_adc_done,
  input wire logic wake_nvm_ready,
  output logic [7:0] osc_trim,
  output logic osc_enable,
  output logic core_clk_domain,
  output logic nvm_clk_domain,
  output logic io_clk_domain,
  output logic adc_clk_domain,
  output logic adc_auto_start,
  output logic core_halted
);
  // Fuse and wake pins synchronised
  logic fuse_s1, fuse_s2;
  logic [3:0] wake_s1, wake_s2;
  logic fuse_seen;
  logic [3:0] divide_select;
  logic divide_change_unlock;
  logic [2:0] unlock_count;
  logic sleep_allow;
  logic [1:0] sleep_kind;
  cpsc_state_t state;
  logic [1:0] cur_kind;
  logic [3:0] hold_count;
  logic [7:0] prescale_count;
  logic [3:0] active_div;

  // Fuse sync runs through reset so it is settled at release
  always_ff @(posedge clock) begin
    fuse_s1 <= start_div_eight_fuse;
    fuse_s2 <= fuse_s1;
  end

  // Wake pins synchronised, cleared by reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wake_s1 <= 4'h0;
      wake_s2 <= 4'h0;
    end else begin
      wake_s1 <= {wake_nvm_ready, wake_adc_done, wake_ext_level, wake_irq};
      wake_s2 <= wake_s1;
    end
  end

  // Bus decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_trim = (paddr == `CPSC_OFF_TRIM);
  wire hit_div = (paddr == `CPSC_OFF_DIV);
  wire hit_sleep = (paddr == `CPSC_OFF_SLEEP);
  wire hit_stat = (paddr == `CPSC_OFF_STATUS);
  wire hit_any = hit_trim || hit_div || hit_sleep || hit_stat;
  wire wr_div = wr && hit_div;
  wire unlock_wr = wr_div && (pwdata[7:0] == `CPSC_UNLOCK_WRITE);
  wire div_wr = wr_div && divide_change_unlock &&
                !pwdata[`CPSC_DIV_UNLOCK_BIT];
  wire [31:0] div_rd = {24'h0000_00, divide_change_unlock, 3'h0,
                        divide_select};
  wire [31:0] next_prdata =
    hit_trim ? {24'h0000_00, osc_trim} :
    hit_div ? div_rd :
    hit_sleep ? {29'h0000_0000, sleep_allow, sleep_kind} :
    hit_stat ? {26'h0000_000, core_halted, osc_enable, active_div} :
    32'h0000_0000;

  // APB answer one cycle after access phase starts
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc && !pready;
      prdata <= (acc && !pwrite) ? next_prdata : prdata;
      pslverr <= acc && !pready && !hit_any;
    end
  end
  wire commit = wr && pready;

  // trim reload on first cycle after reset release, software write
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      osc_trim <= 8'h00;
    else if (!fuse_seen)
      osc_trim <= FACTORY_TRIM;
    else if (commit && hit_trim)
      osc_trim <= pwdata[7:0];
  end

  // reset value from fuse after release
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fuse_seen <= 1'b0;
      divide_select <= `CPSC_DIV_RESET_PLAIN;
    end else if (!fuse_seen) begin
      fuse_seen <= 1'b1;
      divide_select <= fuse_s2 ? `CPSC_DIV_RESET_EIGHT :
                       `CPSC_DIV_RESET_PLAIN;
    end else if (div_wr && pready) begin
      divide_select <= pwdata[3:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      divide_change_unlock <= 1'b0;
      unlock_count <= 3'h0;
    end else if (divide_change_unlock) begin
      if ((div_wr && pready) || unlock_count == `CPSC_UNLOCK_CYCLES - 3'h1)
        divide_change_unlock <= 1'b0;
      unlock_count <= unlock_count + 3'h1;
    end else if (unlock_wr && pready) begin
      divide_change_unlock <= 1'b1;
      unlock_count <= 3'h0;
    end
  end

  // Sleep control register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sleep_allow <= 1'b0;
      sleep_kind <= 2'h0;
    end else if (commit && hit_sleep) begin
      sleep_allow <= pwdata[`CPSC_SLEEP_ALLOW_BIT];
      sleep_kind <= pwdata[1:0];
    end
  end

  function automatic logic [3:0] cpsc_clamp(input logic [3:0] code);
    cpsc_clamp = (code > `CPSC_DIV_MAX) ? `CPSC_DIV_MAX : code;
  endfunction
  function automatic logic [7:0] cpsc_mask(input logic [3:0] code);
    logic [8:0] full;
    full = 9'h001 << cpsc_clamp(code);
    cpsc_mask = 8'(full - 9'h001);
  endfunction

  // new rate after current period ends
  wire period_end = ((prescale_count & cpsc_mask(active_div)) ==
                     cpsc_mask(active_div));
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prescale_count <= 8'h00;
      active_div <= 4'h0;
    end else begin
      if (period_end) begin
        prescale_count <= 8'h00;
        active_div <= cpsc_clamp(divide_select);
      end else begin
        prescale_count <= prescale_count + 8'h01;
      end
    end
  end

  // Wake sources allowed per sleep kind
  wire [3:0] w = wake_s2;
  wire wake_ok =
    (cur_kind == 2'(CPSC_IDLE)) ? (|w) :
    (cur_kind == 2'(CPSC_ADC_QUIET)) ? (w[1] || w[2] || w[3]) :
    w[1];
  wire [3:0] wake_len =
    (cur_kind == 2'(CPSC_STANDBY)) ? `CPSC_STANDBY_WAKE_CYCLES :
    (cur_kind == 2'(CPSC_POWER_DOWN)) ? `CPSC_POWERDOWN_WAKE_CYCLES +
                                        `CPSC_WAKE_HOLD_CYCLES :
    `CPSC_WAKE_HOLD_CYCLES;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= CPSC_RUN;
      cur_kind <= 2'h0;
      hold_count <= 4'h0;
    end else begin
      case (state)
        CPSC_RUN: begin
          if (sleep_req && sleep_allow) begin
            state <= CPSC_SLEEP;
            cur_kind <= sleep_kind;
          end
        end
        CPSC_SLEEP: begin
          if (wake_ok) begin
            state <= CPSC_WAKE;
            hold_count <= 4'h0;
          end
        end
        CPSC_WAKE: begin
          hold_count <= hold_count + 4'h1;
          if (hold_count == wake_len - 4'h1)
            state <= CPSC_RUN;
        end
        default: state <= CPSC_RUN;
      endcase
    end
  end

  wire in_sleep = (state == CPSC_SLEEP);
  wire deep = in_sleep && (cur_kind[1]);
  wire osc_off = in_sleep && cur_kind == 2'(CPSC_POWER_DOWN);
  wire stop_io = in_sleep && cur_kind != 2'(CPSC_IDLE);
  wire stop_core = (state != CPSC_RUN);
  wire stop_slow = in_sleep && cur_kind != 2'(CPSC_IDLE) &&
                   cur_kind != 2'(CPSC_ADC_QUIET);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      osc_enable <= 1'b1;
      core_clk_domain <= 1'b0;
      nvm_clk_domain <= 1'b0;
      io_clk_domain <= 1'b0;
      adc_clk_domain <= 1'b0;
      adc_auto_start <= 1'b0;
      core_halted <= 1'b0;
    end else begin
      osc_enable <= !osc_off;
      core_clk_domain <= period_end && !stop_core;
      nvm_clk_domain <= period_end && !stop_core;
      io_clk_domain <= period_end && !stop_io && !deep;
      adc_clk_domain <= period_end && !stop_slow;
      adc_auto_start <= (state == CPSC_RUN) && sleep_req && sleep_allow &&
                        !sleep_kind[1];
      core_halted <= stop_core;
    end
  end

  // Unlock window never exceeds four cycles
  AST_UNLOCK_WINDOW: assert property (
    @(posedge clock) disable iff (rst)
    $rose(divide_change_unlock) |-> ##[1:4] !divide_change_unlock)
    else $error("unlock stayed open too long");
  // Unlock rises only after exact pattern
  AST_UNLOCK_PATTERN: assert property (
    @(posedge clock) disable iff (rst)
    $rose(divide_change_unlock) |-> $past(unlock_wr && pready))
    else $error("unlock set without pattern");
  // Divide changes only inside the window, reset load excluded
  AST_DIV_GUARD: assert property (
    @(posedge clock) disable iff (rst)
    ($changed(divide_select) && $past(fuse_seen)) |->
      $past(divide_change_unlock))
    else $error("divide changed without unlock");
  // Reserved bits read zero
  AST_RSVD_ZERO: assert property (
    @(posedge clock) disable iff (rst)
    div_rd[6:4] == 3'h0)
    else $error("reserved prescaler bits set");
  // Sleep needs permission
  AST_SLEEP_ALLOW: assert property (
    @(posedge clock) disable iff (rst)
    (state == CPSC_RUN && sleep_req && !sleep_allow) |=>
      state == CPSC_RUN)
    else $error("slept without permission");
  // Allowed request halts the core two edges later
  AST_SLEEP_ENTRY: assert property (
    @(posedge clock) disable iff (rst)
    (state == CPSC_RUN && sleep_req && sleep_allow) |-> ##2 core_halted)
    else $error("allowed sleep not entered");
  // Idle keeps io domain ticking
  AST_IDLE_IO: assert property (
    @(posedge clock) disable iff (rst)
    (in_sleep && cur_kind == 2'(CPSC_IDLE) && period_end) |=>
      io_clk_domain)
    else $error("idle stopped io clock");
  // Light sleep entry starts the converter
  AST_ADC_START: assert property (
    @(posedge clock) disable iff (rst)
    (state == CPSC_RUN && sleep_req && sleep_allow && !sleep_kind[1]) |=>
      adc_auto_start)
    else $error("no converter start on entry");
  // Quiet mode gates io domain
  AST_QUIET_IO: assert property (
    @(posedge clock) disable iff (rst)
    (in_sleep && cur_kind == 2'(CPSC_ADC_QUIET)) |=> !io_clk_domain)
    else $error("io clock in quiet mode");
  // Power-down stops oscillator
  AST_PD_OSC: assert property (
    @(posedge clock) disable iff (rst)
    osc_off |=> !osc_enable)
    else $error("oscillator ran in power-down");
  // Deep modes gate converter domain
  AST_DEEP_ADC: assert property (
    @(posedge clock) disable iff (rst)
    (in_sleep && cur_kind[1]) |=> !adc_clk_domain)
    else $error("converter clock in deep sleep");
  // Standby keeps the oscillator
  AST_STANDBY_OSC: assert property (
    @(posedge clock) disable iff (rst)
    (in_sleep && cur_kind == 2'(CPSC_STANDBY)) |=> osc_enable)
    else $error("oscillator stopped in standby");
  // Core held at least four cycles on wake
  AST_WAKE_HOLD: assert property (
    @(posedge clock) disable iff (rst)
    $rose(state == CPSC_WAKE) |-> (state == CPSC_WAKE)[*4])
    else $error("wake hold too short");
  // Standby wakes in six cycles
  AST_STANDBY_WAKE: assert property (
    @(posedge clock) disable iff (rst)
    ($rose(state == CPSC_WAKE) && cur_kind == 2'(CPSC_STANDBY))
      |-> ##6 state == CPSC_RUN)
    else $error("standby wake not six cycles");
  // Core domain gated while not running
  AST_CORE_GATE: assert property (
    @(posedge clock) disable iff (rst)
    stop_core |=> !core_clk_domain)
    else $error("core clock during sleep");
  // Factory trim loaded after every reset
  AST_TRIM_RELOAD: assert property (
    @(posedge clock) disable iff (rst)
    !fuse_seen |=> osc_trim == FACTORY_TRIM)
    else $error("factory trim not loaded");
  // Programmed fuse starts at divide by eight
  AST_DIV_RESET: assert property (
    @(posedge clock) disable iff (rst)
    (!fuse_seen && fuse_s2) |=> divide_select == `CPSC_DIV_RESET_EIGHT)
    else $error("fuse reset divide wrong");
  // Committed divide value stored as written
  AST_DIV_ANY: assert property (
    @(posedge clock) disable iff (rst)
    (div_wr && pready) |=> divide_select == $past(pwdata[3:0]))
    else $error("divide value not stored");
  // Divide write closes the window
  AST_DIV_CLOSES: assert property (
    @(posedge clock) disable iff (rst)
    (div_wr && pready) |=> !divide_change_unlock)
    else $error("unlock open after divide write");
  // Rewrite inside window keeps it open
  AST_UNLOCK_REWRITE: assert property (
    @(posedge clock) disable iff (rst)
    (divide_change_unlock && unlock_wr && pready &&
     unlock_count != `CPSC_UNLOCK_CYCLES - 3'h1) |=> divide_change_unlock)
    else $error("rewrite cleared unlock");
  // Active rate changes only at a period end
  AST_SWITCH_EDGE: assert property (
    @(posedge clock) disable iff (rst)
    $changed(active_div) |-> $past(period_end))
    else $error("rate switched mid period");
endmodule // cpsc_clock_ctrl
`default_nettype wire

// >>> testbench/cpsc_core_model.sv
// Core model issuing APB register cycles and sleep requests
`include "cpsc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module cpsc_core_model (
  input wire logic clock,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic sleep_req
);
  int stalls = 0;
  logic [31:0] rdata;
  logic rerr;
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    sleep_req = 1'b0;
  end
  // One transfer held until pready; caller releases
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) stalls++; // Counted as a mismatch at the end
    rdata = prdata;
    rerr = pslverr;
  endtask
  // Release the bus for one cycle
  task idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // unlock and divide sent with nothing between
  task unlock_div(input logic [31:0] first, input logic [31:0] d);
    xfer(1'b1, `CPSC_OFF_DIV, first);
    xfer(1'b1, `CPSC_OFF_DIV, d);
    idle();
  endtask
  // no NVM writes issued, so any trim is safe
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    idle();
  endtask
  task rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0000_0000);
    idle();
  endtask
  task sleep_pulse();
    sleep_req <= 1'b1;
    @(posedge clock);
    sleep_req <= 1'b0;
  endtask
endmodule // cpsc_core_model
`default_nettype wire

// >>> testbench/cpsc_clock_ctrl_tb.sv
// Self-checking bench of the clock prescaler and sleep controller
`include "cpsc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module cpsc_clock_ctrl_tb;
  typedef struct {logic [7:0] w; logic [3:0] c; int p;} cpsc_row_t;
  cpsc_row_t rows [10] = '{'{8'h01, 4'h1, 2}, '{8'h02, 4'h2, 4},
    '{8'h03, 4'h3, 8}, '{8'h04, 4'h4, 16}, '{8'h75, 4'h5, 32},
    '{8'h06, 4'h6, 64}, '{8'h07, 4'h7, 128}, '{8'h08, 4'h8, 256},
    '{8'h09, 4'h9, 256}, '{8'h00, 4'h0, 1}};
  logic [7:0] trims [4] = '{8'h7F, 8'h80, 8'h00, 8'hFF};
  int hold [4] = '{4, 4, 10, 6};
  int src [4] = '{0, 2, 1, 1};
  logic clock, rst, fuse, psel, penable, pwrite, pready, pslverr, sleep_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] wk;
  logic [7:0] osc_trim;
  logic osc_enable, core_d, nvm_d, io_d, adc_d, adc_start, halted;
  int mismatches = 0;
  int checks_done = 0;
  int core_n = 0, nvm_n = 0, io_n = 0, adc_n = 0, st_n = 0;
  int p, n, c0, n0, i0, a0, s0;
  cpsc_clock_ctrl #(.FACTORY_TRIM(8'hC3)) i_cpsc_clock_ctrl (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .start_div_eight_fuse(fuse), .sleep_req(sleep_req),
    .ext_crystal_sel(1'b0), .wake_irq(wk[0]), .wake_ext_level(wk[1]),
    .wake_adc_done(wk[2]), .wake_nvm_ready(wk[3]), .osc_trim(osc_trim),
    .osc_enable(osc_enable), .core_clk_domain(core_d), .nvm_clk_domain(nvm_d),
    .io_clk_domain(io_d), .adc_clk_domain(adc_d), .adc_auto_start(adc_start),
    .core_halted(halted));
  cpsc_core_model i_cpsc_core_model (.clock(clock), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .sleep_req(sleep_req));
  // Master clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Domain enable and auto-start pulse counters
  always @(posedge clock) begin
    if (core_d === 1'b1) core_n <= core_n + 1;
    if (nvm_d === 1'b1) nvm_n <= nvm_n + 1;
    if (io_d === 1'b1) io_n <= io_n + 1;
    if (adc_d === 1'b1) adc_n <= adc_n + 1;
    if (adc_start === 1'b1) st_n <= st_n + 1;
  end
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    i_cpsc_core_model.rd(a);
    check(what, exp, i_cpsc_core_model.rdata);
  endtask
  // Cycles between two core enables, after one settling period
  task period();
    repeat (2) begin
      n = 0;
      while (core_d !== 1'b1 && n < 600) begin
        @(posedge clock);
        n++;
      end
      i0 = io_n;
      p = 0;
      do begin
        @(posedge clock);
        p++;
      end while (core_d !== 1'b1 && p < 600);
    end
  endtask
  task tally_and_finish();
    mismatches += i_cpsc_core_model.stalls;
    if (mismatches == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (40000) @(posedge clock);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    fuse = 1'b1;
    wk = 4'h0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    check("trim pin", 32'h0000_00C3, 32'(osc_trim));
    rdc("trim reg", `CPSC_OFF_TRIM, 32'h0000_00C3);
    rdc("div reset", `CPSC_OFF_DIV, 32'(`CPSC_DIV_RESET_EIGHT));
    period();
    check("reset period", 32'h0000_0008, 32'(p));
    foreach (trims[i]) begin
      i_cpsc_core_model.wr(`CPSC_OFF_TRIM, 32'(trims[i]));
      check("trim write", 32'(trims[i]), 32'(osc_trim));
    end
    rdc("unmapped", 12'h010, 32'h0000_0000);
    check("slverr", 32'h0000_0001, 32'(i_cpsc_core_model.rerr));
    foreach (rows[i]) begin
      i_cpsc_core_model.unlock_div(32'(`CPSC_UNLOCK_WRITE), 32'(rows[i].w));
      period();
      check("period", 32'(rows[i].p), 32'(p));
      check("io per period", 32'h0000_0001, 32'(io_n - i0));
      rdc("divide", `CPSC_OFF_DIV, 32'(rows[i].c));
      rdc("status", `CPSC_OFF_STATUS, 32'h0000_0010 |
          32'(rows[i].c > 4'h8 ? 4'h8 : rows[i].c));
    end
    i_cpsc_core_model.unlock_div(32'h0000_0081, 32'h0000_0002);
    rdc("bad unlock", `CPSC_OFF_DIV, 32'h0000_0000);
    i_cpsc_core_model.wr(`CPSC_OFF_DIV, 32'(`CPSC_UNLOCK_WRITE));
    repeat (6) @(posedge clock);
    rdc("unlock lapsed", `CPSC_OFF_DIV, 32'h0000_0000);
    i_cpsc_core_model.wr(`CPSC_OFF_DIV, 32'h0000_0002);
    rdc("late divide", `CPSC_OFF_DIV, 32'h0000_0000);
    i_cpsc_core_model.wr(`CPSC_OFF_SLEEP, 32'h0000_0000);
    i_cpsc_core_model.sleep_pulse();
    repeat (5) @(posedge clock);
    check("no allow", 32'h0000_0000, 32'(halted));
    for (int k = 0; k < 4; k++) begin
      i_cpsc_core_model.wr(`CPSC_OFF_SLEEP, 32'h0000_0004 | 32'(k));
      s0 = st_n;
      i_cpsc_core_model.sleep_pulse();
      repeat (4) @(posedge clock);
      c0 = core_n;
      n0 = nvm_n;
      i0 = io_n;
      a0 = adc_n;
      repeat (20) @(posedge clock);
      check("halted", 32'h0000_0001, 32'(halted));
      check("core clk", 32'h0000_0000, 32'(core_n - c0));
      check("nvm clk", 32'h0000_0000, 32'(nvm_n - n0));
      check("io clk", k == 0 ? 20 : 0, 32'(io_n - i0));
      check("adc clk", k < 2 ? 20 : 0, 32'(adc_n - a0));
      check("osc", 32'(k != 2), 32'(osc_enable));
      check("adc start", 32'(k < 2), 32'(st_n - s0));
      if (k > 0) begin
        wk[0] <= 1'b1;
        repeat (10) @(posedge clock);
        check("false wake", 32'h0000_0001, 32'(halted));
        wk[0] <= 1'b0;
        @(posedge clock);
      end
      wk[src[k]] <= 1'b1;
      n = 0;
      while (halted !== 1'b0 && n < 30) begin
        @(posedge clock);
        n++;
      end
      // Two sync edges, one decision edge, hold, one output edge, one edge to sample it
      check("wake time", 32'(hold[k] + 5), 32'(n));
      wk <= 4'h0;
      @(posedge clock);
    end
    i_cpsc_core_model.wr(`CPSC_OFF_SLEEP, 32'h0000_0006);
    i_cpsc_core_model.sleep_pulse();
    fuse <= 1'b0;
    repeat (3) @(posedge clock);
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    check("reset wake", 32'h0000_0000, 32'(halted));
    rdc("div plain", `CPSC_OFF_DIV, 32'(`CPSC_DIV_RESET_PLAIN));
    rdc("trim reload", `CPSC_OFF_TRIM, 32'h0000_00C3);
    tally_and_finish();
  end
endmodule // cpsc_clock_ctrl_tb
`default_nettype wire
